// ---- design/mbi_pkg.sv ----
package mbi_pkg;

  // bus widths and address spaces
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 16;
  localparam int ROW_W = 8;
  localparam int TIMER_BIT = 18;
  localparam int N_XFER = 2;

  // fixed vector and values after reset
  localparam logic [15:0] NMI_VECTOR = 16'h0066;
  localparam logic [7:0] ROW_RST = 8'h00;
  localparam logic REF_CLK_RST = 1'b0;
  localparam logic TIMER_SEL_RST = 1'b0;

  // machine cycle kinds requested by the core
  typedef enum logic [2:0] {
    KIND_MEM_RD,
    KIND_MEM_WR,
    KIND_IO_RD,
    KIND_IO_WR,
    KIND_FETCH,
    KIND_ACK0,
    KIND_ACK12,
    KIND_REFRESH
  } mbi_kind_t;

  // t-state sequencer
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_T1,
    SEQ_T2,
    SEQ_TW,
    SEQ_T3,
    SEQ_HOLD
  } mbi_state_t;

  // cycle kinds that strobe the read line
  function automatic logic mbi_is_read(input mbi_kind_t k);
    return (k == KIND_MEM_RD) || (k == KIND_IO_RD) || (k == KIND_FETCH) || (k == KIND_ACK0);
  endfunction : mbi_is_read

  // cycle kinds that drive the data bus
  function automatic logic mbi_is_write(input mbi_kind_t k);
    return (k == KIND_MEM_WR) || (k == KIND_IO_WR);
  endfunction : mbi_is_write

endpackage : mbi_pkg

// ---- design/mbi_clk_half.sv ----
`timescale 1ns/1ps
module mbi_clk_half
  import mbi_pkg::*;
(
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // halved reference clock
  output logic ref_clk
);

  logic ref_clk_q;

  // toggle every rising edge to halve the input rate
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ref_clk_q <= REF_CLK_RST;
    else
      ref_clk_q <= ~ref_clk_q;
  end

  assign ref_clk = ref_clk_q;

endmodule : mbi_clk_half

// ---- design/mbi_xfer_detect.sv ----
`timescale 1ns/1ps
module mbi_xfer_detect
  import mbi_pkg::*;
(
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // request pin and mode
  input logic req_n,
  input logic edge_mode,
  input logic ack,
  // pending request to the channel
  output logic pending
);

  logic prev_q;
  logic edge_q;
  logic level_q;

  // previous pin level for falling edge detect
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prev_q <= 1'b1;
    else
      prev_q <= req_n;
  end

  // edge latch, a new edge wins over the acknowledge
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      edge_q <= 1'b0;
    else if (prev_q && !req_n)
      edge_q <= 1'b1;
    else if (ack)
      edge_q <= 1'b0;
  end

  // level sense follows the active low pin
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      level_q <= 1'b0;
    else
      level_q <= ~req_n;
  end

  assign pending = edge_mode ? edge_q : level_q;

endmodule : mbi_xfer_detect

// ---- design/mbi_bus_unit.sv ----
// Contract
// - twenty-bit address reaches 1 MB memory and 64 KB I/O space.
// - address outputs float during reset and while bus is granted.
// - A18 pin shares timer pulse output; address function after reset.
// - hold request outranks NMI, taken at cycle end, floats bus.
// - 8-bit data bus floats during reset and external grant.
// - reference clock output runs at half the input clock.
// - transfer requests active low, level or edge sensed per channel.
// - stopped output low after halt or sleep until interrupt.
// - irq0 taken at instruction end or while stopped, only without NMI or hold; fetch+io ack.
// - irq1/irq2 need NMI, hold, irq0 inactive; ack asserts neither strobe.
// - io request low for valid I/O address and irq0 acknowledge.
// - memory request low while address valid for memory access.
// - fetch strobe with memory on opcode fetch, with io on ack.
// - NMI falling edge outranks maskable, ignores enable, vector 0066h.
// - refresh strobe with memory request, row on low eight bits.
// - status flag, stopped, fetch encode the machine cycle type.
// - transfer done low during final write cycle of the channel.
// - wait sampled at T2 fall and each wait state; low inserts waits.
// - write strobe low only while data bus holds valid data.
`timescale 1ns/1ps
module mbi_bus_unit
  import mbi_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // core cycle requests
  input logic cyc_req,
  input mbi_kind_t cyc_kind,
  input logic [AW-1:0] cyc_addr,
  input logic [DW-1:0] cyc_wdata,
  input logic cyc_first_fetch,
  input logic cyc_dma,
  input logic [N_XFER-1:0] cyc_last_write,
  output logic cyc_done,
  output logic [DW-1:0] cyc_rdata,
  // core instruction and interrupt status
  input logic instr_end,
  input logic int_enable,
  input logic halt_req,
  input logic sleep_req,
  output logic take_nmi,
  output logic take_irq0,
  output logic take_irq1,
  output logic take_irq2,
  output logic [15:0] take_vector,
  // transfer channel side
  input logic [N_XFER-1:0] xfer_edge_mode,
  input logic [N_XFER-1:0] xfer_ack,
  output logic [N_XFER-1:0] xfer_pending,
  // timer side
  input logic timer_out_en,
  input logic timer_pulse_in,
  // address and data pins
  output logic [AW-1:0] addr_o,
  output logic addr_oe,
  input logic [DW-1:0] data_i,
  output logic [DW-1:0] data_o,
  output logic data_oe,
  // strobes, three-state group shares ctl_oe
  output logic mem_request_n,
  output logic io_request_n,
  output logic read_n,
  output logic write_n,
  output logic ctl_oe,
  output logic fetch_cycle_n,
  output logic refresh_n,
  output logic cycle_kind_flag,
  output logic stopped_n,
  output logic ref_clk_out,
  // external masters and request pins
  input logic hold_request_n,
  output logic grant_n,
  input logic wait_n,
  input logic nonmask_n,
  input logic irq_zero_n,
  input logic irq_one_n,
  input logic irq_two_n,
  input logic xfer_request0_n,
  input logic xfer_request1_n,
  output logic xfer_done0_n,
  output logic xfer_done1_n
);

  // widths the pin map cannot serve are refused
  if (AW != ADDR_W || DW != DATA_W)
    $error("mbi_bus_unit: address must be 20 bits and data 8 bits");

  mbi_state_t state_q;
  mbi_kind_t kind_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic [ROW_W-1:0] row_q;
  logic first_q, dma_q, done_q, wait_seen_q;
  logic [N_XFER-1:0] last_q;
  logic timer_sel_q, timer_q;
  logic nmi_prev_q, nmi_pend_q, halt_q, sleep_q;
  logic tnmi_q, tirq0_q, tirq1_q, tirq2_q;
  logic [15:0] vector_q;
  logic tstate_end, active, wr_phase, decide;
  logic [N_XFER-1:0] req_pins, done_n;

  // reference clock; its low half closes each t-state
  mbi_clk_half u_clk (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ref_clk (ref_clk_out)
  );
  assign tstate_end = ~ref_clk_out;

  // sequencer: hold is checked only between machine cycles
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= SEQ_IDLE;
    else if (tstate_end)
    begin
      unique case (state_q)
        SEQ_IDLE: state_q <= !hold_request_n ? SEQ_HOLD : (cyc_req ? SEQ_T1 : SEQ_IDLE);
        SEQ_T1: state_q <= SEQ_T2;
        SEQ_T2, SEQ_TW: state_q <= wait_seen_q ? SEQ_TW : SEQ_T3;
        SEQ_T3: state_q <= !hold_request_n ? SEQ_HOLD : SEQ_IDLE;
        SEQ_HOLD: state_q <= hold_request_n ? SEQ_IDLE : SEQ_HOLD;
      endcase
    end
  end

  // wait pin sampled at the falling edge inside T2 and TW
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      wait_seen_q <= 1'b0;
    else if ((state_q == SEQ_T2 || state_q == SEQ_TW) && ref_clk_out)
      wait_seen_q <= ~wait_n;
  end

  // cycle capture; refresh places the row, io stays in 64 KB
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      kind_q <= KIND_MEM_RD;
      addr_q <= '0;
      wdata_q <= '0;
      first_q <= 1'b0;
      dma_q <= 1'b0;
      last_q <= '0;
    end
    else if (tstate_end && state_q == SEQ_IDLE && hold_request_n && cyc_req)
    begin
      kind_q <= cyc_kind;
      wdata_q <= cyc_wdata;
      first_q <= cyc_first_fetch;
      dma_q <= cyc_dma;
      last_q <= cyc_last_write;
      if (cyc_kind == KIND_REFRESH)
        addr_q <= {{(AW-ROW_W){1'b0}}, row_q};
      else if (cyc_kind == KIND_IO_RD || cyc_kind == KIND_IO_WR || cyc_kind == KIND_ACK0)
        addr_q <= {{(AW-IO_ADDR_W){1'b0}}, cyc_addr[IO_ADDR_W-1:0]};
      else
        addr_q <= cyc_addr;
    end
  end

  // refresh row advances after each refresh cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      row_q <= ROW_RST;
    else if (tstate_end && state_q == SEQ_T3 && kind_q == KIND_REFRESH)
      row_q <= row_q + 8'h01;
  end

  // completion pulse and read capture at the end of T3
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      done_q <= tstate_end && state_q == SEQ_T3;
      if (tstate_end && state_q == SEQ_T3 && mbi_is_read(kind_q))
        rdata_q <= data_i;
    end
  end
  assign cyc_done = done_q;
  assign cyc_rdata = rdata_q;

  // timer select latched clear at reset so the pin starts as address
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      timer_sel_q <= TIMER_SEL_RST;
      timer_q <= 1'b0;
    end
    else
    begin
      timer_sel_q <= timer_out_en;
      timer_q <= timer_pulse_in;
    end
  end

  // address pins with the shared timer bit
  always_comb
  begin
    addr_o = addr_q;
    if (timer_sel_q)
      addr_o[TIMER_BIT] = timer_q;
  end

  // strobes decode from the registered cycle
  assign active = !sys_rst && (state_q == SEQ_T1 || state_q == SEQ_T2 || state_q == SEQ_TW || state_q == SEQ_T3);
  assign wr_phase = active && state_q != SEQ_T1 && mbi_is_write(kind_q);
  assign addr_oe = !sys_rst && state_q != SEQ_HOLD;
  assign ctl_oe = addr_oe;
  assign data_oe = active && mbi_is_write(kind_q);
  assign data_o = wdata_q;
  assign mem_request_n = !(active && (kind_q == KIND_MEM_RD || kind_q == KIND_MEM_WR ||
                                      kind_q == KIND_FETCH || kind_q == KIND_REFRESH));
  assign io_request_n = !(active && (kind_q == KIND_IO_RD || kind_q == KIND_IO_WR ||
                                     kind_q == KIND_ACK0));
  assign read_n = !(active && mbi_is_read(kind_q));
  assign write_n = !wr_phase;
  assign refresh_n = !(active && kind_q == KIND_REFRESH);
  assign grant_n = state_q != SEQ_HOLD;
  assign stopped_n = !(halt_q || sleep_q);

  // status encoding: halt 0,0,0  sleep 1,0,1  dma 0,1,1
  always_comb
  begin
    if (halt_q)
    begin
      cycle_kind_flag = 1'b0;
      fetch_cycle_n = 1'b0;
    end
    else if (sleep_q)
    begin
      cycle_kind_flag = 1'b1;
      fetch_cycle_n = 1'b1;
    end
    else
    begin
      fetch_cycle_n = !(active && (kind_q == KIND_FETCH || kind_q == KIND_ACK0));
      cycle_kind_flag = !(active && (dma_q || (kind_q == KIND_FETCH && first_q)));
    end
  end

  // transfer request detectors and done strobes per channel
  assign req_pins = {xfer_request1_n, xfer_request0_n};
  for (genvar i = 0; i < N_XFER; i++)
  begin : g_xfer
    mbi_xfer_detect u_det (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .req_n (req_pins[i]),
      .edge_mode (xfer_edge_mode[i]),
      .ack (xfer_ack[i]),
      .pending (xfer_pending[i])
    );
    assign done_n[i] = !(active && mbi_is_write(kind_q) && last_q[i]);
  end
  assign xfer_done0_n = done_n[0];
  assign xfer_done1_n = done_n[1];

  // nmi edge latch; a new edge wins over the clear
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end
    else
    begin
      nmi_prev_q <= nonmask_n;
      if (nmi_prev_q && !nonmask_n)
        nmi_pend_q <= 1'b1;
      else if (tnmi_q)
        nmi_pend_q <= 1'b0;
    end
  end

  // arbitration at instruction end or while stopped
  assign decide = (instr_end || halt_q || sleep_q) && !(tnmi_q || tirq0_q || tirq1_q || tirq2_q);
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tnmi_q <= 1'b0;
      tirq0_q <= 1'b0;
      tirq1_q <= 1'b0;
      tirq2_q <= 1'b0;
      vector_q <= '0;
    end
    else
    begin
      tnmi_q <= decide && hold_request_n && nmi_pend_q;
      tirq0_q <= decide && hold_request_n && !nmi_pend_q && int_enable && !irq_zero_n;
      tirq1_q <= decide && hold_request_n && !nmi_pend_q && int_enable && irq_zero_n && !irq_one_n;
      tirq2_q <= decide && hold_request_n && !nmi_pend_q && int_enable && irq_zero_n && irq_one_n &&
                 !irq_two_n;
      if (decide && hold_request_n && nmi_pend_q)
        vector_q <= NMI_VECTOR;
    end
  end
  assign take_nmi = tnmi_q;
  assign take_irq0 = tirq0_q;
  assign take_irq1 = tirq1_q;
  assign take_irq2 = tirq2_q;
  assign take_vector = vector_q;

  // stopped state held until an interrupt is taken
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      halt_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      // a new stop request wins over a take in the same cycle
      if (halt_req)
        halt_q <= 1'b1;
      else if (tnmi_q || tirq0_q || tirq1_q || tirq2_q)
        halt_q <= 1'b0;
      if (sleep_req)
        sleep_q <= 1'b1;
      else if (tnmi_q || tirq0_q || tirq1_q || tirq2_q)
        sleep_q <= 1'b0;
    end
  end

  // checks
  sequence s_wait_low;
    (state_q == SEQ_T2 || state_q == SEQ_TW) && ref_clk_out && !wait_n;
  endsequence
  sequence s_wait_state;
    ##2 state_q == SEQ_TW;
  endsequence

  chk_addr_float: assert property (@(posedge sys_clk) disable iff (sys_rst) !grant_n |-> !addr_oe && !ctl_oe)
    else $error("address driven while granted");
  chk_data_float: assert property (@(posedge sys_clk) disable iff (sys_rst) !grant_n |-> !data_oe)
    else $error("data driven while granted");
  chk_clock_half: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> ref_clk_out != $past(ref_clk_out))
    else $error("reference clock not halved");
  chk_a18_reset: assert property (@(posedge sys_clk) $fell(sys_rst) |-> !timer_sel_q && addr_o == addr_q)
    else $error("A18 not address after reset");
  chk_nmi_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) take_nmi |-> $past(hold_request_n))
    else $error("nmi taken over hold request");
  chk_irq0_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    take_irq0 |-> $past(hold_request_n) && !$past(nmi_pend_q))
    else $error("irq0 taken while blocked");
  chk_irq12_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take_irq1 || take_irq2) |-> $past(irq_zero_n) && !$past(nmi_pend_q))
    else $error("irq1/2 taken while blocked");
  chk_ack0_strobes: assert property (@(posedge sys_clk) disable iff (sys_rst)
    active && kind_q == KIND_ACK0 && !halt_q && !sleep_q |-> !fetch_cycle_n && !io_request_n)
    else $error("irq0 acknowledge strobes wrong");
  chk_ack12_strobes: assert property (@(posedge sys_clk) disable iff (sys_rst)
    active && kind_q == KIND_ACK12 |-> io_request_n && mem_request_n)
    else $error("irq1/2 acknowledge strobes io");
  chk_wait_insert: assert property (@(posedge sys_clk) disable iff (sys_rst) s_wait_low |-> s_wait_state)
    else $error("wait state not inserted");
  chk_write_data: assert property (@(posedge sys_clk) disable iff (sys_rst) !write_n |-> data_oe)
    else $error("write strobe without data");
  chk_refresh_mem: assert property (@(posedge sys_clk) disable iff (sys_rst) !refresh_n |-> !mem_request_n)
    else $error("refresh without memory request");
  chk_halt_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(halt_q) |-> !stopped_n && !cycle_kind_flag && !fetch_cycle_n)
    else $error("halt status code wrong");
  chk_grant_stay: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !grant_n && !hold_request_n |=> !grant_n)
    else $error("grant dropped while requested");
  chk_done_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!xfer_done0_n || !xfer_done1_n) |-> data_oe)
    else $error("transfer done outside write");

endmodule : mbi_bus_unit

// ---- testbench/mbi_far_side.sv ----
`timescale 1ns/1ps
module mbi_far_side
  import mbi_pkg::*;
(
  // clock
  input logic sys_clk,
  // pins seen from the bus
  input logic [19:0] addr_o,
  input logic ctl_oe,
  input logic mem_request_n,
  input logic io_request_n,
  input logic read_n,
  // wait states asked per cycle
  input logic [3:0] waits,
  // answer to the processor
  output logic [7:0] pdata,
  output logic wait_n
);
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic sel;
  assign sel = ctl_oe && !(mem_request_n && io_request_n);
  // count cycles with a strobe low
  always_ff @(posedge sys_clk)
    cnt_q <= sel ? cnt_q + 8'h01 : 8'h00;
  // hold wait low across the asked number of wait-state samples
  assign wait_n = !(sel && cnt_q < 8'(2 * waits + 2));
  // drive data only while read is low, else an inverted stale value
  always_ff @(posedge sys_clk)
    if (sel && !read_n)
      last_q <= addr_o[7:0] ^ 8'h5a;
  assign pdata = (sel && !read_n) ? (addr_o[7:0] ^ 8'h5a) : ~last_q;
endmodule : mbi_far_side

// ---- testbench/mpu_external_bus_interface_bench.sv ----
`timescale 1ns/1ps
module mpu_external_bus_interface_bench import mbi_pkg::*;;
  logic sys_clk = 1'b0, sys_rst = 1'b1, cyc_req = 1'b0, cyc_first_fetch = 1'b0, instr_end = 1'b0;
  logic int_enable = 1'b0, halt_req = 1'b0, sleep_req = 1'b0, timer_out_en = 1'b0, timer_pulse_in = 1'b0;
  logic hold_request_n = 1'b1, nonmask_n = 1'b1, irq_zero_n = 1'b1, irq_one_n = 1'b1, irq_two_n = 1'b1;
  logic xfer_request0_n = 1'b1, xfer_request1_n = 1'b1, cyc_dma = 1'b0, dma_code = 1'b0;
  logic [1:0] cyc_last_write = 2'b00, xfer_edge_mode = 2'b00, xfer_ack = 2'b00, xfer_pending;
  logic [19:0] cyc_addr = 20'h00000, addr_o, seen_addr;
  logic [7:0] cyc_wdata = 8'h00, data_i, data_o, pdata, cyc_rdata, seen;
  logic [3:0] waits = 4'h0;
  logic [15:0] take_vector;
  mbi_kind_t cyc_kind = KIND_MEM_RD;
  logic cyc_done, take_nmi, take_irq0, take_irq1, take_irq2, addr_oe, data_oe, mem_request_n, io_request_n;
  logic read_n, write_n, ctl_oe, fetch_cycle_n, refresh_n, cycle_kind_flag, stopped_n, ref_clk_out;
  logic grant_n, wait_n, xfer_done0_n, xfer_done1_n;
  int fails = 0, samples_checked = 0;
  // data bus seen by the design
  assign data_i = data_oe ? data_o : pdata;
  mbi_bus_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cyc_req(cyc_req), .cyc_kind(cyc_kind),
    .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_first_fetch(cyc_first_fetch), .cyc_dma(cyc_dma),
    .cyc_last_write(cyc_last_write), .cyc_done(cyc_done), .cyc_rdata(cyc_rdata), .instr_end(instr_end),
    .int_enable(int_enable), .halt_req(halt_req), .sleep_req(sleep_req), .take_nmi(take_nmi),
    .take_irq0(take_irq0), .take_irq1(take_irq1), .take_irq2(take_irq2), .take_vector(take_vector),
    .xfer_edge_mode(xfer_edge_mode), .xfer_ack(xfer_ack), .xfer_pending(xfer_pending),
    .timer_out_en(timer_out_en), .timer_pulse_in(timer_pulse_in), .addr_o(addr_o), .addr_oe(addr_oe),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe), .mem_request_n(mem_request_n),
    .io_request_n(io_request_n), .read_n(read_n), .write_n(write_n), .ctl_oe(ctl_oe),
    .fetch_cycle_n(fetch_cycle_n), .refresh_n(refresh_n), .cycle_kind_flag(cycle_kind_flag),
    .stopped_n(stopped_n), .ref_clk_out(ref_clk_out), .hold_request_n(hold_request_n), .grant_n(grant_n),
    .wait_n(wait_n), .nonmask_n(nonmask_n), .irq_zero_n(irq_zero_n), .irq_one_n(irq_one_n),
    .irq_two_n(irq_two_n), .xfer_request0_n(xfer_request0_n), .xfer_request1_n(xfer_request1_n),
    .xfer_done0_n(xfer_done0_n), .xfer_done1_n(xfer_done1_n));
  mbi_far_side far_u (.sys_clk(sys_clk), .addr_o(addr_o), .ctl_oe(ctl_oe), .mem_request_n(mem_request_n),
    .io_request_n(io_request_n), .read_n(read_n), .waits(waits), .pdata(pdata), .wait_n(wait_n));
  // 250 MHz clock
  initial
    forever #2 sys_clk = ~sys_clk;
  // gather strobe activity of one machine cycle
  always @(posedge sys_clk)
    if (ctl_oe === 1'b1)
    begin
      seen |= {!fetch_cycle_n && !cycle_kind_flag && !mem_request_n,
        !(cyc_last_write[1] ? xfer_done1_n : xfer_done0_n),
        (!write_n && !(data_oe && data_o === cyc_wdata)) || (!refresh_n && addr_o !== {12'h000, ROW_RST}),
        !write_n && data_oe && data_o === cyc_wdata, !refresh_n, !fetch_cycle_n, !io_request_n, !mem_request_n};
      if (refresh_n && !(mem_request_n && io_request_n))
        seen_addr = addr_o;
      // dma status code: flag low, fetch high, not stopped
      if (!cycle_kind_flag && fetch_cycle_n && stopped_n && !mem_request_n)
        dma_code = 1'b1;
    end
  task automatic check(input string nm, input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // one machine cycle, judged on length, strobes, address and read data
  task automatic run(input mbi_kind_t k, input logic [19:0] a, input logic ff, input logic [3:0] w,
    input logic [7:0] es);
    int n;
    logic [19:0] m;
    n = 0;
    @(posedge sys_clk);
    seen = 8'h00;
    waits <= w;
    cyc_kind <= k;
    cyc_addr <= a;
    cyc_wdata <= a[7:0] ^ 8'h3c;
    cyc_first_fetch <= ff;
    cyc_last_write <= {k == KIND_IO_WR, k == KIND_MEM_WR};
    cyc_req <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (cyc_done !== 1'b1 && n < 80);
    cyc_req <= 1'b0;
    m = (es[1] ? 20'h0ffff : 20'hfffff) & ~{1'b0, timer_out_en, 18'h0};
    check("cycle_len", 20'(n >= 8 + 2 * w && n <= 9 + 2 * w), 20'h1);
    check("strobes", {12'h0, seen}, {12'h0, es});
    if (k == KIND_MEM_RD)
      check("rdata", {12'h0, cyc_rdata}, {12'h0, a[7:0] ^ 8'h5a});
    if ((es[0] || es[1]) && !es[3])
      check("addr", seen_addr & m, a & m);
  endtask : run
  // pulse instruction end and collect take pulses
  task automatic instr(output logic [3:0] tk);
    tk = 4'h0;
    @(posedge sys_clk);
    instr_end <= 1'b1;
    @(posedge sys_clk);
    instr_end <= 1'b0;
    repeat (4)
    begin
      @(negedge sys_clk);
      tk |= {take_nmi, take_irq0, take_irq1, take_irq2};
    end
    @(posedge sys_clk);
  endtask : instr
  task automatic t_cycles();
    mbi_kind_t ks[10] = '{KIND_MEM_RD, KIND_MEM_WR, KIND_IO_RD, KIND_IO_WR, KIND_FETCH, KIND_FETCH,
      KIND_ACK0, KIND_ACK12, KIND_REFRESH, KIND_MEM_RD};
    logic [7:0] es[10] = '{8'h01, 8'h51, 8'h02, 8'h52, 8'h85, 8'h05, 8'h06, 8'h00, 8'h09, 8'h01};
    for (int i = 0; i < 10; i++)
      run(ks[i], 20'hfa5c3 + 20'(i), i == 4, (i == 9) ? 4'h2 : 4'h0, es[i]);
    @(posedge sys_clk);
    timer_out_en <= 1'b1;
    timer_pulse_in <= 1'b1;
    run(KIND_MEM_RD, 20'h01234, 1'b0, 4'h0, 8'h01);
    check("timer_pin", seen_addr[18], 1'b1);
    timer_out_en <= 1'b0;
    check("no_dma_code", dma_code, 1'b0);
    cyc_dma <= 1'b1;
    run(KIND_MEM_RD, 20'h00777, 1'b0, 4'h0, 8'h01);
    cyc_dma <= 1'b0;
    check("dma_code", dma_code, 1'b1);
  endtask : t_cycles
  task automatic t_irq();
    logic [3:0] tk;
    @(posedge sys_clk);
    int_enable <= 1'b1;
    irq_zero_n <= 1'b0;
    nonmask_n <= 1'b0;
    instr(tk);
    check("take_nmi", tk, 4'h8);
    check("vector", take_vector, 16'h0066);
    instr(tk);
    check("take_irq0", tk, 4'h4);
    irq_zero_n <= 1'b1;
    irq_one_n <= 1'b0;
    irq_two_n <= 1'b0;
    int_enable <= 1'b0;
    instr(tk);
    check("masked", tk, 4'h0);
    int_enable <= 1'b1;
    instr(tk);
    check("take_irq1", tk, 4'h2);
    irq_one_n <= 1'b1;
    instr(tk);
    check("take_irq2", tk, 4'h1);
    irq_two_n <= 1'b1;
    nonmask_n <= 1'b1;
  endtask : t_irq
  task automatic t_hold();
    logic [3:0] tk;
    @(posedge sys_clk);
    hold_request_n <= 1'b0;
    irq_zero_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check("grant", {grant_n, addr_oe, data_oe, ctl_oe}, 4'h0);
    instr(tk);
    check("held_take", tk, 4'h0);
    repeat (20) @(posedge sys_clk);
    check("grant_kept", grant_n, 1'b0);
    hold_request_n <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check("retake", {grant_n, ctl_oe}, 2'b11);
    instr(tk);
    check("late_irq0", tk, 4'h4);
    irq_zero_n <= 1'b1;
  endtask : t_hold
  task automatic t_stop();
    @(posedge sys_clk);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check("halt", {cycle_kind_flag, stopped_n, fetch_cycle_n}, 3'b000);
    @(posedge sys_clk);
    irq_two_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check("wake", stopped_n, 1'b1);
    @(posedge sys_clk);
    irq_two_n <= 1'b1;
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check("sleep", {cycle_kind_flag, stopped_n, fetch_cycle_n}, 3'b101);
    @(posedge sys_clk);
    nonmask_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check("wake_nmi", stopped_n, 1'b1);
    @(posedge sys_clk);
    nonmask_n <= 1'b1;
  endtask : t_stop
  task automatic t_xfer();
    @(posedge sys_clk);
    xfer_edge_mode <= 2'b10;
    xfer_request0_n <= 1'b0;
    xfer_request1_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    xfer_request1_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check("pending", xfer_pending, 2'b11);
    @(posedge sys_clk);
    xfer_request0_n <= 1'b1;
    xfer_ack <= 2'b10;
    @(posedge sys_clk);
    xfer_ack <= 2'b00;
    repeat (3) @(negedge sys_clk);
    check("cleared", xfer_pending, 2'b00);
  endtask : t_xfer
  // watchdog
  initial
  begin
    #40000;
    fails++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    logic r;
    repeat (15) @(posedge sys_clk);
    @(negedge sys_clk);
    check("reset_float", {grant_n, addr_oe, data_oe, ctl_oe}, 4'h8);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge sys_clk);
    r = ref_clk_out;
    @(negedge sys_clk);
    check("ref_clk", ref_clk_out, !r);
    t_cycles();
    t_irq();
    t_hold();
    t_stop();
    t_xfer();
    print_verdict();
  end
endmodule : mpu_external_bus_interface_bench
